// *** hw/adcsc_pkg.sv ***
package adcsc_pkg;

    // ****************************************************************
    // Register word indexes on the 4-bit register port
    // ****************************************************************
    localparam logic [3:0] REG_CTRL2   = 4'h1;
    localparam logic [3:0] REG_CTRL3   = 4'h2;
    localparam logic [3:0] REG_CTRL4   = 4'h3;
    localparam logic [3:0] REG_CTRL5   = 4'h4;
    localparam logic [3:0] REG_STATUS  = 4'h5;
    localparam logic [3:0] REG_TEST    = 4'h6;
    localparam int         RESULT_BIT  = 3;   // Index bit 3 set: results

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int C2_POWER_UP = 7;   // converter_power_up
    localparam int C2_WAIT_PD  = 6;   // wait_power_down_enable
    localparam int C2_IRQ_EN   = 1;   // Sequence interrupt enable
    localparam int C3_LEN8     = 3;   // sequence_length_select, high
    localparam int C4_RES8     = 7;   // Eight-bit resolution
    localparam int C4_SMP_LO   = 5;   // sample_time_select, 2 bits
    localparam int C4_PRS_LO   = 0;   // Prescale modulus, 5 bits
    localparam int C5_RJUST    = 7;   // Right-justified results
    localparam int C5_SPECIAL  = 6;   // special_reference_convert
    localparam int C5_CONT     = 5;   // Continuous sequences
    localparam int C5_SEVERAL_CHANNEL_PASS     = 4;   // several_channel_pass
    localparam int C5_LEN1     = 3;   // sequence_length_select, low
    localparam int C5_CHAN_LO  = 0;   // channel_select_field, 3 bits
    localparam int ST_SCF      = 15;  // sequence_done_flag
    localparam int TEST_RST    = 0;   // Module soft reset

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] CTRL_RST = 8'h00;

    // ****************************************************************
    // Timing in module clocks
    // ****************************************************************
    localparam logic [4:0] T_SAMPLE1   = 5'h02;
    localparam logic [4:0] T_TRANSFER  = 5'h04;
    localparam logic [4:0] T_FINAL_MIN = 5'h02;
    localparam logic [4:0] T_SAR_SETTLE = 5'h02;
    localparam logic [3:0] TOP_BIT_10  = 4'h9;
    localparam logic [3:0] TOP_BIT_8   = 4'h7;
    localparam int         PRS_WIDTH   = 5;

    // ****************************************************************
    // Conversion phases
    // ****************************************************************
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_SAMPLE,
        PH_TRANSFER,
        PH_FINAL,
        PH_CONVERT
    } adcsc_phase_t;

endpackage

// *** hw/adcsc_prescaler.sv ***
`timescale 1ns/1ps
module adcsc_prescaler #(
    parameter int WIDTH = 5
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // Control
    input  wire logic             enable,
    input  wire logic [WIDTH-1:0] modulus,
    // Module clock enable
    output logic                  tick
);

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic             half;
        logic             tick;
    } adcsc_prs_t;

    adcsc_prs_t s;
    adcsc_prs_t next_s;

    // Modulus counter then divide by two, one pulse per module clock
    always_comb
    begin
        next_s = s;
        next_s.tick = 1'b0;
        if (!enable)
        begin
            next_s.cnt = '0;
            next_s.half = 1'b0;
        end
        else if (s.cnt == modulus)
        begin
            next_s.cnt = '0;
            next_s.half = ~s.half;
            next_s.tick = s.half;  // [RULE_18]
        end
        else
        begin
            next_s.cnt = s.cnt + 1'b1;
        end
    end

    // State register
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            s <= '0;
        else
            s <= next_s;
    end

    assign tick = s.tick;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_tick_gap;
        tick |=> !tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap) // [RULE_18]
        else $error("Module clock faster than half the bus clock");

endmodule

// *** hw/adcsc_top.sv ***
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// RULE_01: Eight channels, one engine, 10 or 8 bits
// RULE_02: Sequences hold one, four or eight conversions
// RULE_03: Single channel, or step across channels
// RULE_04: Continuous restarts, otherwise one sequence then stop
// RULE_05: Special mode converts references or midpoint
// RULE_06: Three-bit field picks (first) channel
// RULE_07: Two length bits in two registers
// RULE_08: Two-bit field picks final sample time
// RULE_09: Writing control four/five restarts sequence
// RULE_10: Continuous stops only on listed events
// RULE_11: Sequence done flag set per sequence
// RULE_12: Per-result done flag set on load
// RULE_13: Optional interrupt on sequence completion
// RULE_14: Sixteen 16-bit register words
// RULE_15: Left or right justified results
// RULE_16: Sample 2, transfer 4, final 2-16 clocks
// RULE_17: Approximation takes 10 or 12 clocks
// RULE_18: Five-bit prescaler then divide by two
// RULE_19: Power down aborts sequence
// RULE_20: Conversion n goes to result n
module adcsc_top (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [15:0] reg_rdata,
    // System power states
    input  wire logic        stop_req,
    input  wire logic        wait_req,
    // Analog front end
    input  wire logic        comp_high,
    output logic      [2:0]  mux_channel,
    output logic             special_select,
    output logic      [1:0]  sample_phase,
    output logic      [9:0]  dac_code,
    output logic             convert_busy,
    // Completion
    output logic             irq
);

    typedef struct packed {
        adcsc_pkg::adcsc_phase_t phase;
        logic [4:0]        cnt;
        logic [2:0]        idx;
        logic [3:0]        bitpos;
        logic [9:0]        sar;
        logic [7:0][15:0]  result;
        logic [7:0]        ccf;
        logic              sequence_done_flag;
        logic [7:0]        ctl2;
        logic [7:0]        ctl3;
        logic [7:0]        ctl4;
        logic [7:0]        ctl5;
        logic [15:0]       rdata;
        logic              irq;
        logic [2:0]        chan;
        logic              special;
        logic [1:0]        sphase;
        logic [9:0]        dac;
        logic              busy;
        logic              sync1;
        logic              sync2;
    } adcsc_state_t;

    adcsc_state_t s;
    adcsc_state_t next_s;
    logic         tick;

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Last conversion index of a sequence: eight, one or four
    function automatic logic [2:0] seq_last(input logic len8,
                                            input logic len1);
        if (len8)
            seq_last = 3'h7;
        else if (len1)
            seq_last = 3'h0;
        else
            seq_last = 3'h3;
    endfunction

    // Final sample phase length minus one: 2, 4, 8 or 16
    function automatic logic [4:0] final_last(input logic [1:0] smp);
        final_last = (adcsc_pkg::T_FINAL_MIN << smp) - 5'h01;
    endfunction

    // Channel of conversion idx within the sequence
    function automatic logic [2:0] chan_of(input logic [7:0] ctl5,
                                           input logic [2:0] idx);
        logic [2:0] base;
        base = ctl5[adcsc_pkg::C5_CHAN_LO +: 3];
        if (ctl5[adcsc_pkg::C5_SEVERAL_CHANNEL_PASS])
            chan_of = base + idx;
        else
            chan_of = base;
    endfunction

    // Place a finished code in the result word
    function automatic logic [15:0] fmt(input logic [9:0] code,
                                        input logic res8,
                                        input logic rjust);
        if (res8 && rjust)
            fmt = {8'h00, code[7:0]};
        else if (res8)
            fmt = {code[7:0], 8'h00};
        else if (rjust)
            fmt = {6'h00, code};
        else
            fmt = {code, 6'h00};
    endfunction

    // ****************************************************************
    // Module clock
    // ****************************************************************

    // Prescaler runs only while a sequence is active
    adcsc_prescaler #(
        .WIDTH   (adcsc_pkg::PRS_WIDTH)
    ) u_prescaler (
        .clock   (clock),
        .rst_n   (rst_n),
        .enable  (s.busy),
        .modulus (s.ctl4[adcsc_pkg::C4_PRS_LO +: adcsc_pkg::PRS_WIDTH]),
        .tick    (tick)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    logic       halt;
    logic       start;
    logic       soft_rst;
    logic       res8;
    logic [7:0] set_ccf;
    logic [7:0] clr_ccf;
    logic       set_scf;
    logic       clr_scf;

    // Sequencer, register port and output staging
    always_comb
    begin
        next_s = s;
        set_ccf = 8'h00;
        clr_ccf = 8'h00;
        set_scf = 1'b0;
        clr_scf = 1'b0;
        res8 = s.ctl4[adcsc_pkg::C4_RES8];
        next_s.sync1 = comp_high;
        next_s.sync2 = s.sync1;
        // Power down by control bit, stop, or wait when enabled
        halt = !s.ctl2[adcsc_pkg::C2_POWER_UP] || stop_req
               || (wait_req && s.ctl2[adcsc_pkg::C2_WAIT_PD]);  // [RULE_10]
        start = reg_write && (reg_addr == adcsc_pkg::REG_CTRL4
                || reg_addr == adcsc_pkg::REG_CTRL5);           // [RULE_09]
        soft_rst = reg_write && reg_addr == adcsc_pkg::REG_TEST
                   && reg_wdata[adcsc_pkg::TEST_RST];

        // Conversion phases, advanced on each module clock
        if (tick)
        begin
            unique case (s.phase)
                adcsc_pkg::PH_IDLE:
                begin
                    next_s.phase = adcsc_pkg::PH_IDLE;
                end
                adcsc_pkg::PH_SAMPLE:
                begin
                    if (s.cnt == 5'h00)
                    begin
                        next_s.phase = adcsc_pkg::PH_TRANSFER;
                        next_s.cnt = adcsc_pkg::T_TRANSFER - 5'h01; // [RULE_16]
                    end
                    else
                        next_s.cnt = s.cnt - 5'h01;
                end
                adcsc_pkg::PH_TRANSFER:
                begin
                    if (s.cnt == 5'h00)
                    begin
                        next_s.phase = adcsc_pkg::PH_FINAL;
                        next_s.cnt = final_last(
                            s.ctl4[adcsc_pkg::C4_SMP_LO +: 2]);     // [RULE_08]
                    end
                    else
                        next_s.cnt = s.cnt - 5'h01;
                end
                adcsc_pkg::PH_FINAL:
                begin
                    if (s.cnt == 5'h00)
                    begin
                        next_s.phase = adcsc_pkg::PH_CONVERT;
                        next_s.cnt = adcsc_pkg::T_SAR_SETTLE;       // [RULE_17]
                        next_s.bitpos = res8 ? adcsc_pkg::TOP_BIT_8
                                             : adcsc_pkg::TOP_BIT_10; // [RULE_01]
                        next_s.sar = 10'h000;
                        next_s.sar[next_s.bitpos] = 1'b1;
                    end
                    else
                        next_s.cnt = s.cnt - 5'h01;
                end
                adcsc_pkg::PH_CONVERT:
                begin
                    if (s.cnt != 5'h00)
                        next_s.cnt = s.cnt - 5'h01;
                    else
                    begin
                        // Binary search: keep trial bit if input is above
                        if (!s.sync2)
                            next_s.sar[s.bitpos] = 1'b0;
                        if (s.bitpos != 4'h0)
                        begin
                            next_s.bitpos = s.bitpos - 4'h1;
                            next_s.sar[next_s.bitpos] = 1'b1;
                        end
                        else
                        begin
                            next_s.result[s.idx] = fmt(next_s.sar, res8,
                                s.ctl5[adcsc_pkg::C5_RJUST]); // [RULE_15] [RULE_20]
                            set_ccf[s.idx] = 1'b1;            // [RULE_12]
                            next_s.phase = adcsc_pkg::PH_SAMPLE;
                            next_s.cnt = adcsc_pkg::T_SAMPLE1 - 5'h01;
                            next_s.idx = s.idx + 3'h1;
                            if (s.idx == seq_last(s.ctl3[adcsc_pkg::C3_LEN8],
                                    s.ctl5[adcsc_pkg::C5_LEN1]))  // [RULE_02] [RULE_07]
                            begin
                                set_scf = 1'b1;                   // [RULE_11]
                                next_s.idx = 3'h0;
                                if (!s.ctl5[adcsc_pkg::C5_CONT])
                                    next_s.phase = adcsc_pkg::PH_IDLE; // [RULE_04]
                            end
                        end
                    end
                end
            endcase
        end

        // Register writes, one 16-bit word per index
        if (reg_write)
        begin
            unique case (reg_addr)
                adcsc_pkg::REG_CTRL2:  next_s.ctl2 = reg_wdata[7:0];
                adcsc_pkg::REG_CTRL3:  next_s.ctl3 = reg_wdata[7:0];
                adcsc_pkg::REG_CTRL4:  next_s.ctl4 = reg_wdata[7:0];
                adcsc_pkg::REG_CTRL5:  next_s.ctl5 = reg_wdata[7:0];
                adcsc_pkg::REG_STATUS:
                begin
                    clr_ccf = reg_wdata[7:0];
                    clr_scf = reg_wdata[adcsc_pkg::ST_SCF];
                end
                default:
                begin
                    clr_scf = 1'b0;
                end
            endcase
        end

        // Sticky flags: a set in the same cycle beats a clear
        next_s.ccf = (s.ccf & ~clr_ccf) | set_ccf;
        next_s.sequence_done_flag = (s.sequence_done_flag & ~clr_scf) | set_scf;

        // New sequence with the freshly written settings
        if (start)
        begin
            next_s.phase = adcsc_pkg::PH_SAMPLE;
            next_s.cnt = adcsc_pkg::T_SAMPLE1 - 5'h01;           // [RULE_16]
            next_s.idx = 3'h0;
        end

        // Power down or module reset aborts everything in flight
        if (halt)
            next_s.phase = adcsc_pkg::PH_IDLE;                   // [RULE_19]
        if (soft_rst)
        begin
            next_s.phase = adcsc_pkg::PH_IDLE;
            next_s.ccf = 8'h00;
            next_s.sequence_done_flag = 1'b0;
            next_s.ctl2 = {s.ctl2[adcsc_pkg::C2_POWER_UP], 7'h00};
            next_s.ctl3 = adcsc_pkg::CTRL_RST;
            next_s.ctl4 = adcsc_pkg::CTRL_RST;
            next_s.ctl5 = adcsc_pkg::CTRL_RST;
        end

        // Read data for the cycle after the strobe; holes read zero
        next_s.rdata = 16'h0000;
        if (reg_read)
        begin
            if (reg_addr[adcsc_pkg::RESULT_BIT])
                next_s.rdata = s.result[reg_addr[2:0]];          // [RULE_14]
            else
            begin
                unique case (reg_addr)
                    adcsc_pkg::REG_CTRL2:  next_s.rdata = {8'h00, s.ctl2};
                    adcsc_pkg::REG_CTRL3:  next_s.rdata = {8'h00, s.ctl3};
                    adcsc_pkg::REG_CTRL4:  next_s.rdata = {8'h00, s.ctl4};
                    adcsc_pkg::REG_CTRL5:  next_s.rdata = {8'h00, s.ctl5};
                    adcsc_pkg::REG_STATUS:
                        next_s.rdata = {s.sequence_done_flag, 7'h00, s.ccf};
                    default:               next_s.rdata = 16'h0000;
                endcase
            end
        end

        // Front-end controls staged from the next state
        next_s.busy = next_s.phase != adcsc_pkg::PH_IDLE;
        next_s.chan = chan_of(next_s.ctl5, next_s.idx);          // [RULE_03] [RULE_06]
        next_s.special = next_s.ctl5[adcsc_pkg::C5_SPECIAL];     // [RULE_05]
        unique case (next_s.phase)
            adcsc_pkg::PH_SAMPLE:   next_s.sphase = 2'h1;
            adcsc_pkg::PH_TRANSFER: next_s.sphase = 2'h2;
            adcsc_pkg::PH_FINAL:    next_s.sphase = 2'h3;
            default:                next_s.sphase = 2'h0;
        endcase
        if (next_s.phase != adcsc_pkg::PH_CONVERT)
            next_s.dac = 10'h000;
        else if (next_s.ctl4[adcsc_pkg::C4_RES8])
            next_s.dac = {next_s.sar[7:0], 2'h0};
        else
            next_s.dac = next_s.sar;
        next_s.irq = next_s.sequence_done_flag && next_s.ctl2[adcsc_pkg::C2_IRQ_EN]; // [RULE_13]
    end

    // State register
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            s <= '0;
        else
            s <= next_s;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign reg_rdata      = s.rdata;
    assign mux_channel    = s.chan;
    assign special_select = s.special;
    assign sample_phase   = s.sphase;
    assign dac_code       = s.dac;
    assign convert_busy   = s.busy;
    assign irq            = s.irq;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_last_store;
        s.phase == adcsc_pkg::PH_CONVERT && tick && s.cnt == 5'h00
        && s.bitpos == 4'h0;
    endsequence

    property p_transfer_len;
        s.phase == adcsc_pkg::PH_SAMPLE && tick && s.cnt == 5'h00 && !start
        && !halt && !soft_rst |=> s.phase == adcsc_pkg::PH_TRANSFER
        && s.cnt == 5'h03;
    endproperty
    a_transfer_len: assert property (p_transfer_len) // [RULE_16]
        else $error("Transfer phase not four module clocks");

    property p_final_len;
        $changed(s.phase) && s.phase == adcsc_pkg::PH_FINAL |->
        s.cnt == final_last(s.ctl4[adcsc_pkg::C4_SMP_LO +: 2]);
    endproperty
    a_final_len: assert property (p_final_len) // [RULE_08]
        else $error("Final sample length wrong");

    property p_convert_entry;
        $changed(s.phase) && s.phase == adcsc_pkg::PH_CONVERT |->
        s.cnt == 5'h02 && s.bitpos == (s.ctl4[adcsc_pkg::C4_RES8] ?
        4'h7 : 4'h9);
    endproperty
    a_convert_entry: assert property (p_convert_entry) // [RULE_17]
        else $error("Approximation start wrong");

    property p_ccf_set;
        s_last_store ##0 !soft_rst |=> s.ccf[$past(s.idx)];
    endproperty
    a_ccf_set: assert property (p_ccf_set) // [RULE_12]
        else $error("Result flag not set on load");

    property p_scf_irq;
        s_last_store ##0 (!soft_rst && s.idx == seq_last(
        s.ctl3[adcsc_pkg::C3_LEN8], s.ctl5[adcsc_pkg::C5_LEN1])) |=>
        s.sequence_done_flag ##1 (irq == (s.sequence_done_flag && s.ctl2[adcsc_pkg::C2_IRQ_EN]));
    endproperty
    a_scf_irq: assert property (p_scf_irq) // [RULE_11]
        else $error("Sequence flag or interrupt missing");

    property p_start;
        start && !halt && !soft_rst |=> s.phase == adcsc_pkg::PH_SAMPLE
        && s.idx == 3'h0 && s.cnt == 5'h01 ##1 convert_busy;
    endproperty
    a_start: assert property (p_start) // [RULE_09]
        else $error("Write did not restart the sequence");

    property p_halt;
        halt |=> s.phase == adcsc_pkg::PH_IDLE ##1 !convert_busy;
    endproperty
    a_halt: assert property (p_halt) // [RULE_19]
        else $error("Power down did not abort");

    property p_single_chan;
        convert_busy && !s.ctl5[adcsc_pkg::C5_SEVERAL_CHANNEL_PASS] && $stable(s.ctl5) |->
        mux_channel == s.ctl5[adcsc_pkg::C5_CHAN_LO +: 3];
    endproperty
    a_single_chan: assert property (p_single_chan) // [RULE_03]
        else $error("Channel moved in single channel mode");

    property p_read_zero;
        reg_read && !reg_addr[adcsc_pkg::RESULT_BIT]
        && (reg_addr > 4'h5 || reg_addr == 4'h0)
        |=> reg_rdata == 16'h0000 ##1 reg_rdata == 16'h0000 || $past(reg_read);
    endproperty
    a_read_zero: assert property (p_read_zero) // [RULE_14]
        else $error("Unmapped word did not read zero");

endmodule

// *** testbench/adcsc_analog_model.sv ***
`timescale 1ns/1ps
module adcsc_analog_model (
    // Front end controls
    input  wire logic [2:0] mux_channel,
    input  wire logic       special_select,
    input  wire logic [9:0] dac_code,
    // Comparator
    output logic            comp_high
);
    // ****************************************************************
    // Held input level and comparator
    // ****************************************************************
    logic [9:0] level;

    // Fixed level per channel, or a reference level in special mode
    always_comb
    begin
        if (special_select)
            level = (mux_channel[1:0] == 2'h1) ? 10'h3ff :
                    (mux_channel[1:0] == 2'h2) ? 10'h200 : 10'h000;
        else
            level = 10'h04d + 10'(mux_channel) * 10'h071;
        comp_high = (level >= dac_code);
    end
endmodule

// *** testbench/adc_sequence_control_tb.sv ***
`timescale 1ns/1ps
module adc_sequence_control_tb;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic        clock, rst_n, reg_write, reg_read, stop_req, wait_req;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic        comp_high, special_select, convert_busy, irq;
    logic [2:0]  mux_channel;
    logic [1:0]  sample_phase;
    logic [9:0]  dac_code;
    int          fails = 0, n_tests = 0, n_fin = 0, n_xfer = 0, n, k;

    adcsc_top adcsc_top_i (.clock(clock), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .stop_req(stop_req), .wait_req(wait_req), .comp_high(comp_high),
        .mux_channel(mux_channel), .special_select(special_select),
        .sample_phase(sample_phase), .dac_code(dac_code),
        .convert_busy(convert_busy), .irq(irq));
    adcsc_analog_model adcsc_analog_model_i (.mux_channel(mux_channel),
        .special_select(special_select), .dac_code(dac_code),
        .comp_high(comp_high));

    // Clock and phase length counters
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(posedge clock)
    begin
        n_fin  <= n_fin + int'(sample_phase == 2'h3);
        n_xfer <= n_xfer + int'(sample_phase == 2'h2);
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    function automatic logic [9:0] lv(input int c);
        return 10'h04d + 10'(c) * 10'h071;
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, g);
        n_tests++;
        if (e !== g)
        begin
            $display("Error %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic wait_scf();
        int i;
        for (i = 0; i < 3000; i++)
        begin
            rd(adcsc_pkg::REG_STATUS, d);
            if (d[15] === 1'b1)
                break;
        end
        if (i == 3000)
        begin
            chk("sequence timeout", 16'h0001, 16'h0000);
            end_of_test();
        end
    endtask
    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        {rst_n, reg_write, reg_read, stop_req, wait_req} = 5'h00;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        for (n = 1; n < 5; n++)
        begin
            rd(4'(n), d);
            chk("control reset", 16'h0000, d);
        end
        wr(4'h0, 16'hffff);
        rd(4'h0, d);
        chk("unmapped", 16'h0000, d);
        wr(4'h8, 16'hffff);
        rd(4'h8, d);
        chk("result read only", 16'h0000, d);
        $display("test registers done");
        wr(adcsc_pkg::REG_CTRL2, 16'h0082);
        wr(adcsc_pkg::REG_CTRL4, 16'h0001);
        wr(adcsc_pkg::REG_CTRL5, 16'h008b);
        wait_scf();
        chk("status single", 16'h8001, d);
        rd(4'h8, d);
        chk("result single", {6'h00, lv(3)}, d);
        chk("irq", 16'h0001, {15'h0000, irq});
        chk("busy after one", 16'h0000, {15'h0000, convert_busy});
        wr(adcsc_pkg::REG_STATUS, 16'h80ff);
        rd(adcsc_pkg::REG_STATUS, d);
        chk("status cleared", 16'h0000, d);
        $display("test single done");
        wr(adcsc_pkg::REG_CTRL5, 16'h0016);
        wait_scf();
        chk("status scan", 16'h800f, d);
        for (n = 0; n < 4; n++)
        begin
            rd(4'(8 + n), d);
            chk("scan left", {lv((6 + n) % 8), 6'h00}, d);
        end
        wr(adcsc_pkg::REG_STATUS, 16'h80ff);
        wr(adcsc_pkg::REG_CTRL3, 16'h0008);
        wr(adcsc_pkg::REG_CTRL4, 16'h0081);
        wr(adcsc_pkg::REG_CTRL5, 16'h0090);
        wait_scf();
        chk("status eight", 16'h80ff, d);
        for (n = 0; n < 8; n++)
        begin
            rd(4'(8 + n), d);
            chk("eight bit", {8'h00, 8'(lv(n) >> 2)}, d);
        end
        wr(adcsc_pkg::REG_CTRL3, 16'h0000);
        $display("test scan done");
        for (k = 0; k < 3; k++)
        begin
            wr(adcsc_pkg::REG_STATUS, 16'h80ff);
            wr(adcsc_pkg::REG_CTRL5, 16'h0048 | 16'(k));
            wait_scf();
            rd(4'h8, d);
            chk("special", {k == 1 ? 8'hff : k == 2 ? 8'h80 : 8'h00, 8'h00},
                d);
        end
        wr(adcsc_pkg::REG_STATUS, 16'h80ff);
        wr(adcsc_pkg::REG_CTRL4, 16'h0061);
        n = n_fin;
        k = n_xfer;
        wait_scf();
        chk("final phase", 16'd64, 16'(n_fin - n));
        chk("transfer", 16'd16, 16'(n_xfer - k));
        $display("test timing done");
        wr(adcsc_pkg::REG_STATUS, 16'h80ff);
        wr(adcsc_pkg::REG_CTRL4, 16'h0001);
        wr(adcsc_pkg::REG_CTRL5, 16'h00a8);
        wait_scf();
        wr(adcsc_pkg::REG_STATUS, 16'h80ff);
        wait_scf();
        chk("continuous", 16'h0001, {15'h0000, convert_busy});
        wr(adcsc_pkg::REG_CTRL2, 16'h0000);
        repeat (2) @(posedge clock);
        chk("power down", 16'h0000, {15'h0000, convert_busy});
        for (k = 0; k < 2; k++)
        begin
            wr(adcsc_pkg::REG_CTRL2, 16'h00c2);
            wr(adcsc_pkg::REG_CTRL5, 16'h00a8);
            repeat (20) @(posedge clock);
            chk("running", 16'h0001, {15'h0000, convert_busy});
            {stop_req, wait_req} <= k == 0 ? 2'h2 : 2'h1;
            repeat (3) @(posedge clock);
            chk("stop or wait", 16'h0000, {15'h0000, convert_busy});
            {stop_req, wait_req} <= 2'h0;
        end
        wr(adcsc_pkg::REG_TEST, 16'h0001);
        rd(adcsc_pkg::REG_CTRL2, d);
        chk("soft reset", 16'h0080, d);
        rd(adcsc_pkg::REG_STATUS, d);
        chk("soft flags", 16'h0000, d);
        $display("test continuous done");
        end_of_test();
    end
endmodule
